/* File: rtl/fac_core.sv */
/*
 * Flash accelerator: configuration registers on classic Wishbone plus the
 * fetch control that they steer (code, prefetch and data line latches,
 * programmable fetch duration, invalidation on mode change).
 * Assumes one clock, synchronous inputs, and a flash that presents a
 * full line on flash_line_i by the last cycle of a fetch.
 */
// The Wishbone register port is this design's own decision.
`timescale 1ns/10ps

// Notes on behaviour
// - After reset the mode field reads as disabled and the control word reads zero.
// - Software may change the mode at any time with no precondition.
// - Mode bits 1:0 hold 00 off, 01 partial, 10 full, and software never writes 11.
// - Any change of mode value invalidates every holding latch, except a latch filled in that same cycle, whose fill wins.
// - Reserved bits are written as zero by software and read back here as zero.
// - Timing value n from 1 to 7 makes a fetch last n clocks, and 0 is never programmed.
// - At reset the timing field holds seven, the longest fetch.
// - With a one clock fetch the mode still changes access timing, as a fast hit answers a clock before the fetch.
// - Each register occupies one aligned word whatever its width.
// - Partial mode serves only sequential code hits from latches and prefetches.
// - Full mode serves any hit from its latch and fetches only misses and prefetches.
// - Off mode, and partial mode outside sequential code hits, may use latched data but keep full fetch timing.
module fac_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire fac_pkg::fac_req_s proc_req_i,
    output fac_pkg::fac_rsp_s proc_rsp_o,
    output logic flash_rd_o,
    output logic [fac_pkg::FAC_TAG_W-1:0] flash_addr_o,
    input wire logic [fac_pkg::FAC_LINE_W-1:0] flash_line_i
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [fac_pkg::FAC_MODE_MSB:0] mode_reg;
    logic [fac_pkg::FAC_TIM_MSB:0] tim_reg;
    logic wb_req;
    logic wb_wr;
    logic mode_sel;
    logic tim_sel;
    logic mode_change;
    fac_pkg::fac_state_e state_reg;
    logic [2:0] cnt_reg;
    logic [2:0] len_reg;
    logic [2:0] fetch_len;
    logic pf_op_reg;
    logic dat_op_reg;
    logic use_flash_reg;
    logic [1:0] wsel_reg;
    logic [31:0] hold_word_reg;
    logic [fac_pkg::FAC_LINE_W-1:0] code_line_reg;
    logic [fac_pkg::FAC_LINE_W-1:0] pf_line_reg;
    logic [fac_pkg::FAC_LINE_W-1:0] dat_line_reg;
    logic [fac_pkg::FAC_TAG_W-1:0] code_tag_reg;
    logic [fac_pkg::FAC_TAG_W-1:0] pf_tag_reg;
    logic [fac_pkg::FAC_TAG_W-1:0] dat_tag_reg;
    logic code_v_reg;
    logic pf_v_reg;
    logic dat_v_reg;
    logic [fac_pkg::FAC_TAG_W-1:0] req_tag;
    logic [fac_pkg::FAC_TAG_W-1:0] next_tag;
    logic [1:0] req_wsel;
    logic code_hit;
    logic pf_hit;
    logic dat_hit;
    logic have_latch;
    logic serve_fast;
    logic take;
    logic start_pf;
    logic fetch_done;
    logic [fac_pkg::FAC_LINE_W-1:0] hit_line;
    logic [3:0] rd_cnt_reg;

    // ------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------
    // word aligned decode
    assign mode_sel = (wb_adr_i == fac_pkg::FAC_MODE_CTRL_ADDR);
    assign tim_sel = (wb_adr_i == fac_pkg::FAC_FETCH_TIM_ADDR);
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Write lands at the edge where the master samples ack high
    assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
    assign mode_change = wb_wr && mode_sel && (wb_dat_i[1:0] != mode_reg);

    // One cycle answer, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && mode_sel) begin
                wb_dat_o <= {30'h00000000, mode_reg};
            end else if (wb_req && tim_sel) begin
                wb_dat_o <= {29'h00000000, tim_reg};
            end else begin
                wb_dat_o <= 32'h00000000;
            end
        end
    end

    // Mode control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= fac_pkg::FAC_MODE_RESET;
        end else if (wb_wr && mode_sel) begin
            mode_reg <= wb_dat_i[1:0];
        end
    end

    // Fetch timing register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tim_reg <= fac_pkg::FAC_TIM_RESET;
        end else if (wb_wr && tim_sel) begin
            tim_reg <= wb_dat_i[2:0];
        end
    end

    // ------------------------------------------------------------
    // Hit detection
    // ------------------------------------------------------------
    assign req_tag = proc_req_i.addr[fac_pkg::FAC_WADDR_W-1:2];
    assign req_wsel = proc_req_i.addr[1:0];
    assign next_tag = code_tag_reg + 14'h0001;
    assign code_hit = code_v_reg && (code_tag_reg == req_tag);
    assign pf_hit = pf_v_reg && (pf_tag_reg == req_tag);
    assign dat_hit = dat_v_reg && (dat_tag_reg == req_tag);
    assign have_latch = proc_req_i.is_data ? dat_hit : (code_hit || pf_hit);
    assign hit_line = proc_req_i.is_data ? dat_line_reg :
                      (code_hit ? code_line_reg : pf_line_reg);
    // reserved code falls back to one clock
    assign fetch_len = (tim_reg == 3'h0) ? fac_pkg::FAC_TIM_MIN : tim_reg;

    // partial serves sequential code hits only
    assign serve_fast = have_latch &&
        ((mode_reg == fac_pkg::FAC_MODE_FULL) ||
         ((mode_reg == fac_pkg::FAC_MODE_PART) && !proc_req_i.is_data && proc_req_i.seq));
    assign take = proc_req_i.valid && proc_rsp_o.ready && (state_reg == fac_pkg::FAC_IDLE);
    assign start_pf = !proc_req_i.valid && (state_reg == fac_pkg::FAC_IDLE) && code_v_reg &&
        ((mode_reg == fac_pkg::FAC_MODE_PART) || (mode_reg == fac_pkg::FAC_MODE_FULL)) &&
        !(pf_v_reg && (pf_tag_reg == next_tag));
    assign fetch_done = (state_reg == fac_pkg::FAC_FETCH) && (cnt_reg == 3'h0);

    // ------------------------------------------------------------
    // Fetch sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= fac_pkg::FAC_IDLE;
            cnt_reg <= 3'h0;
            len_reg <= fac_pkg::FAC_TIM_RESET;
            pf_op_reg <= 1'b0;
            dat_op_reg <= 1'b0;
            use_flash_reg <= 1'b0;
            wsel_reg <= 2'h0;
            hold_word_reg <= 32'h00000000;
            flash_rd_o <= 1'b0;
            flash_addr_o <= '0;
            proc_rsp_o <= '0;
        end else begin
            proc_rsp_o.ack <= 1'b0;
            case (state_reg)
                fac_pkg::FAC_IDLE: begin
                    proc_rsp_o.ready <= 1'b1;
                    if (take && serve_fast) begin
                        proc_rsp_o.ack <= 1'b1;
                        proc_rsp_o.rdata <= hit_line[{req_wsel, 5'h00} +: 32];
                    end else if (take || start_pf) begin
                        // hits outside fast path keep fetch timing
                        // one clock fetch still answers a clock after a fast hit
                        state_reg <= fac_pkg::FAC_FETCH;
                        cnt_reg <= fetch_len - 3'h1;
                        len_reg <= fetch_len;
                        pf_op_reg <= start_pf;
                        dat_op_reg <= take && proc_req_i.is_data;
                        use_flash_reg <= start_pf || !have_latch;
                        flash_rd_o <= start_pf || !have_latch;
                        flash_addr_o <= start_pf ? next_tag : req_tag;
                        wsel_reg <= req_wsel;
                        hold_word_reg <= hit_line[{req_wsel, 5'h00} +: 32];
                        proc_rsp_o.ready <= 1'b0;
                    end
                end
                fac_pkg::FAC_FETCH: begin
                    if (cnt_reg == 3'h0) begin
                        state_reg <= fac_pkg::FAC_IDLE;
                        flash_rd_o <= 1'b0;
                        proc_rsp_o.ready <= 1'b1;
                        proc_rsp_o.ack <= !pf_op_reg;
                        proc_rsp_o.rdata <= use_flash_reg ?
                            flash_line_i[{wsel_reg, 5'h00} +: 32] : hold_word_reg;
                    end else begin
                        cnt_reg <= cnt_reg - 3'h1;
                    end
                end
                default: begin
                    state_reg <= fac_pkg::FAC_IDLE;
                    flash_rd_o <= 1'b0;
                    proc_rsp_o.ready <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Holding latches
    // ------------------------------------------------------------
    // Fills win over an invalidation landing in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_v_reg <= 1'b0;
            pf_v_reg <= 1'b0;
            dat_v_reg <= 1'b0;
            code_tag_reg <= '0;
            pf_tag_reg <= '0;
            dat_tag_reg <= '0;
            code_line_reg <= '0;
            pf_line_reg <= '0;
            dat_line_reg <= '0;
        end else begin
            // drop every latch on mode change
            if (mode_change) begin
                code_v_reg <= 1'b0;
                pf_v_reg <= 1'b0;
                dat_v_reg <= 1'b0;
            end
            if (take && serve_fast && !proc_req_i.is_data && !code_hit) begin
                // Sequential run reached the prefetched line
                code_v_reg <= 1'b1;
                code_tag_reg <= pf_tag_reg;
                code_line_reg <= pf_line_reg;
                pf_v_reg <= 1'b0;
            end
            if (fetch_done && use_flash_reg) begin
                if (pf_op_reg) begin
                    pf_v_reg <= 1'b1;
                    pf_tag_reg <= flash_addr_o;
                    pf_line_reg <= flash_line_i;
                end else if (dat_op_reg) begin
                    dat_v_reg <= 1'b1;
                    dat_tag_reg <= flash_addr_o;
                    dat_line_reg <= flash_line_i;
                end else begin
                    code_v_reg <= 1'b1;
                    code_tag_reg <= flash_addr_o;
                    code_line_reg <= flash_line_i;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Counts cycles of an ongoing flash read
    always_ff @(posedge clk_i) begin
        if (rst_i || !flash_rd_o) begin
            rd_cnt_reg <= 4'h0;
        end else begin
            rd_cnt_reg <= rd_cnt_reg + 4'h1;
        end
    end

    chk_reset_mode: assert property (@(posedge clk_i)
        rst_i |=> (mode_reg == 2'h0) && !wb_ack_o)
        else $error("mode not disabled after reset");
    chk_reset_timing: assert property (@(posedge clk_i)
        rst_i |=> (tim_reg == 3'h7))
        else $error("timing not seven after reset");
    chk_mode_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_wr && mode_sel) |=> (mode_reg == $past(wb_dat_i[1:0])) && !wb_ack_o)
        else $error("mode write not taken");
    chk_timing_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_wr && tim_sel) |=> (tim_reg == $past(wb_dat_i[2:0])))
        else $error("timing write not taken");
    chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    chk_mode_inval: assert property (@(posedge clk_i) disable iff (rst_i)
        (mode_change && (state_reg == fac_pkg::FAC_IDLE) && !proc_req_i.valid)
        |=> !code_v_reg && !pf_v_reg && !dat_v_reg)
        else $error("latches survive mode change");
    chk_reserved_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_req && !wb_we_i && mode_sel) |=> wb_ack_o && (wb_dat_o[31:2] == 30'h00000000))
        else $error("reserved mode bits not zero");
    chk_fetch_length: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(flash_rd_o) |-> ({1'b0, len_reg} == rd_cnt_reg))
        else $error("fetch length differs from timing");
    chk_full_hit: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && have_latch && (mode_reg == fac_pkg::FAC_MODE_FULL)) |=> proc_rsp_o.ack)
        else $error("full mode hit not served at once");
    chk_partial_data: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && proc_req_i.is_data && (mode_reg == fac_pkg::FAC_MODE_PART))
        |=> (state_reg == fac_pkg::FAC_FETCH) && !proc_rsp_o.ack)
        else $error("partial mode data access not fetched");

    // Partial mode code paths, fetch entry and off mode timing and prefetch
    chk_partial_seq: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && have_latch && !proc_req_i.is_data && proc_req_i.seq &&
         (mode_reg == fac_pkg::FAC_MODE_PART)) |=> proc_rsp_o.ack)
        else $error("partial mode sequential hit not served");
    chk_partial_branch: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && !proc_req_i.is_data && !proc_req_i.seq && (mode_reg == fac_pkg::FAC_MODE_PART))
        |=> (state_reg == fac_pkg::FAC_FETCH) && !proc_rsp_o.ack)
        else $error("partial mode branch served from latch");
    chk_fetch_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && !serve_fast) |=> (state_reg == fac_pkg::FAC_FETCH) && !proc_rsp_o.ready)
        else $error("slow access did not stall");
    chk_mimic_timing: assert property (@(posedge clk_i) disable iff (rst_i)
        (take && have_latch && (mode_reg == fac_pkg::FAC_MODE_OFF))
        |=> !flash_rd_o && (state_reg == fac_pkg::FAC_FETCH))
        else $error("off mode hit skipped fetch timing");
    chk_no_prefetch: assert property (@(posedge clk_i) disable iff (rst_i)
        ((mode_reg == fac_pkg::FAC_MODE_OFF) && !proc_req_i.valid &&
         (state_reg == fac_pkg::FAC_IDLE)) |=> (state_reg == fac_pkg::FAC_IDLE))
        else $error("prefetch while disabled");

endmodule : fac_core

/* File: rtl/fac_pkg.sv */
/*
 * Package of the flash accelerator configuration block: register byte
 * addresses, field positions, reset values, mode codes, state codes and
 * the packed carriers of the processor request and answer.
 * Assumes a 32-bit classic Wishbone register bus and a 16-bit word
 * address on the processor side.
 */
package fac_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [31:0] FAC_MODE_CTRL_ADDR = 32'hE01FC000;
    localparam logic [31:0] FAC_FETCH_TIM_ADDR = 32'hE01FC004;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int FAC_MODE_MSB = 1;
    localparam int FAC_TIM_MSB = 2;
    localparam logic [1:0] FAC_MODE_RESET = 2'h0;
    localparam logic [2:0] FAC_TIM_RESET = 3'h7;

    // Acceleration modes
    localparam logic [1:0] FAC_MODE_OFF = 2'h0;
    localparam logic [1:0] FAC_MODE_PART = 2'h1;
    localparam logic [1:0] FAC_MODE_FULL = 2'h2;

    // Shortest fetch, used when the reserved timing code is present
    localparam logic [2:0] FAC_TIM_MIN = 3'h1;

    // ------------------------------------------------------------
    // Line geometry
    // ------------------------------------------------------------
    localparam int FAC_WADDR_W = 16;
    localparam int FAC_TAG_W = 14;
    localparam int FAC_LINE_W = 128;

    typedef enum logic [2:0] {
        FAC_IDLE  = 3'h1,
        FAC_FETCH = 3'h2,
        FAC_SPARE = 3'h4
    } fac_state_e;

    typedef struct packed {
        logic valid;
        logic is_data;
        logic seq;
        logic [FAC_WADDR_W-1:0] addr;
    } fac_req_s;

    typedef struct packed {
        logic ready;
        logic ack;
        logic [31:0] rdata;
    } fac_rsp_s;

endpackage : fac_pkg

/* File: test/fac_core_tb.sv */
/*
 * Self-checking bench of the flash accelerator: register reset values,
 * register access on classic Wishbone, fetch duration, hit latency in
 * each mode, miss latency in off and full mode and latch invalidation
 * on a mode change.
 * Assumes fac_pkg is compiled first; the bench stands in for the flash
 * and for the processor.
 */
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin fails++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end

module fac_core_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    fac_pkg::fac_req_s proc_req_i = '0;
    fac_pkg::fac_rsp_s proc_rsp_o;
    logic flash_rd_o;
    logic [13:0] flash_addr_o;
    logic [127:0] flash_line_i;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;

    // ------------------------------------------------------------
    // Clock, flash model and device
    // ------------------------------------------------------------
    always #2 clk_i = ~clk_i;

    function automatic logic [31:0] wd(input logic [13:0] tag, input logic [1:0] k);
        return {16'hF1A5, k, tag};
    endfunction : wd

    function automatic logic [127:0] mk(input logic [13:0] tag);
        return {wd(tag, 2'h3), wd(tag, 2'h2), wd(tag, 2'h1), wd(tag, 2'h0)};
    endfunction : mk

    // Line is garbage outside a fetch so stale sampling shows up
    assign flash_line_i = flash_rd_o ? mk(flash_addr_o) : ~mk(flash_addr_o);

    fac_core DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .proc_req_i(proc_req_i),
        .proc_rsp_o(proc_rsp_o), .flash_rd_o(flash_rd_o), .flash_addr_o(flash_addr_o),
        .flash_line_i(flash_line_i)
    );

    // ------------------------------------------------------------
    // Bus and processor tasks
    // ------------------------------------------------------------
    // One classic cycle, held until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                           input logic [3:0] sel, output logic [31:0] rd);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [31:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] dummy;
        wb_xfer(1'b1, adr, dat, sel, dummy);
    endtask : wr

    task automatic rdr(input logic [31:0] adr, output logic [31:0] rd);
        wb_xfer(1'b0, adr, 32'h0, 4'hF, rd);
    endtask : rdr

    // off, new timing, then the wanted mode
    // the flash model answers at any duration, so each value suits it
    task automatic set_tim(input logic [2:0] n, input logic [1:0] mode);
        wr(fac_pkg::FAC_MODE_CTRL_ADDR, 32'h0, 4'hF);
        wr(fac_pkg::FAC_FETCH_TIM_ADDR, {29'h0, n}, 4'hF);
        wr(fac_pkg::FAC_MODE_CTRL_ADDR, {30'h0, mode}, 4'hF);
        repeat (20) @(posedge clk_i);
    endtask : set_tim

    // Processor access: valid held until taken, then latency and fetch cycles counted
    task automatic acc(input logic is_d, input logic sq, input logic [15:0] a, output int lat,
                       output int nrd, output logic [13:0] fa, output logic [31:0] rd);
        logic done;
        lat = 0;
        nrd = 0;
        fa = 14'h0;
        done = 1'b0;
        @(posedge clk_i);
        proc_req_i <= '{valid: 1'b1, is_data: is_d, seq: sq, addr: a};
        do @(posedge clk_i); while (proc_rsp_o.ready !== 1'b1);
        proc_req_i.valid <= 1'b0;
        // Sample just after each edge, starting with the edge that took the request
        while (!done) begin
            #1;
            lat++;
            if (flash_rd_o === 1'b1) begin
                if (nrd == 0) fa = flash_addr_o;
                nrd++;
            end
            done = (proc_rsp_o.ack === 1'b1) || (lat >= 40);
            if (!done) @(posedge clk_i);
        end
        `CHK(proc_rsp_o.ack, 1'b1)
        rd = proc_rsp_o.rdata;
    endtask : acc

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] rd;
        logic [1:0] modes [4] = '{2'h2, 2'h1, 2'h0, 2'h2};
        rdr(fac_pkg::FAC_MODE_CTRL_ADDR, rd);
        `CHK(rd, 32'h0)
        rdr(fac_pkg::FAC_FETCH_TIM_ADDR, rd);
        `CHK(rd, 32'h7)
        foreach (modes[i]) begin
            wr(fac_pkg::FAC_MODE_CTRL_ADDR, {30'h0, modes[i]}, 4'hF);
            rdr(fac_pkg::FAC_MODE_CTRL_ADDR, rd);
            `CHK(rd, {30'h0, modes[i]})
        end
        wr(fac_pkg::FAC_FETCH_TIM_ADDR, 32'h5, 4'hF);
        rdr(fac_pkg::FAC_FETCH_TIM_ADDR, rd);
        `CHK(rd, 32'h5)
        rdr(fac_pkg::FAC_MODE_CTRL_ADDR, rd);
        `CHK(rd, 32'h2)
        wr(32'hE01FC008, 32'h1, 4'hF);
        rdr(32'hE01FC008, rd);
        `CHK(rd, 32'h0)
        wr(fac_pkg::FAC_MODE_CTRL_ADDR, 32'h1, 4'h0);
        rdr(fac_pkg::FAC_MODE_CTRL_ADDR, rd);
        `CHK(rd, 32'h2)
    endtask : t_regs

    task automatic t_timing();
        int lat;
        int nrd;
        logic [13:0] fa;
        logic [31:0] rd;
        logic [15:0] a;
        for (int n = 1; n <= 7; n++) begin
            set_tim(3'(n), fac_pkg::FAC_MODE_OFF);
            a = 16'(n * 16'h1000 + 16'h0005);
            acc(1'b0, 1'b0, a, lat, nrd, fa, rd);
            `CHK(nrd, n)
            `CHK(lat, n + 1)
            `CHK(fa, a[15:2])
            `CHK(rd, wd(a[15:2], a[1:0]))
        end
    endtask : t_timing

    task automatic t_off_hit();
        int lat;
        int nrd;
        logic [13:0] fa;
        logic [31:0] rd;
        // three clocks suit a clock above 40 MHz
        set_tim(3'h3, fac_pkg::FAC_MODE_OFF);
        acc(1'b0, 1'b0, 16'h6003, lat, nrd, fa, rd);
        acc(1'b0, 1'b0, 16'h6003, lat, nrd, fa, rd);
        `CHK(lat, 4)
        `CHK(nrd, 0)
        `CHK(rd, wd(14'h1800, 2'h3))
    endtask : t_off_hit

    task automatic t_full();
        int lat;
        int nrd;
        logic [13:0] fa;
        logic [31:0] rd;
        set_tim(3'h2, fac_pkg::FAC_MODE_FULL);
        acc(1'b0, 1'b0, 16'h2104, lat, nrd, fa, rd);
        `CHK(lat, 3)
        acc(1'b0, 1'b0, 16'h2105, lat, nrd, fa, rd);
        `CHK(lat, 1)
        `CHK(rd, wd(14'h0841, 2'h1))
        acc(1'b1, 1'b0, 16'h3208, lat, nrd, fa, rd);
        acc(1'b1, 1'b1, 16'h320A, lat, nrd, fa, rd);
        `CHK(lat, 1)
        `CHK(rd, wd(14'h0C82, 2'h2))
        repeat (20) @(posedge clk_i);
        wr(fac_pkg::FAC_MODE_CTRL_ADDR, 32'h1, 4'hF);
        wr(fac_pkg::FAC_MODE_CTRL_ADDR, 32'h2, 4'hF);
        acc(1'b0, 1'b0, 16'h2104, lat, nrd, fa, rd);
        `CHK(nrd, 2)
        `CHK(lat, 3)
    endtask : t_full

    task automatic t_part();
        int lat;
        int nrd;
        logic [13:0] fa;
        logic [31:0] rd;
        set_tim(3'h2, fac_pkg::FAC_MODE_PART);
        acc(1'b0, 1'b0, 16'h4400, lat, nrd, fa, rd);
        acc(1'b0, 1'b1, 16'h4401, lat, nrd, fa, rd);
        `CHK(lat, 1)
        `CHK(rd, wd(14'h1100, 2'h1))
        acc(1'b0, 1'b1, 16'h4404, lat, nrd, fa, rd);
        `CHK(lat, 1)
        `CHK(rd, wd(14'h1101, 2'h0))
        acc(1'b0, 1'b0, 16'h4406, lat, nrd, fa, rd);
        `CHK(lat, 3)
        `CHK(nrd, 0)
        acc(1'b1, 1'b0, 16'h5500, lat, nrd, fa, rd);
        acc(1'b1, 1'b1, 16'h5501, lat, nrd, fa, rd);
        `CHK(lat, 3)
        `CHK(rd, wd(14'h1540, 2'h1))
    endtask : t_part

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // Hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 8000) begin
            fails++;
            complete_run();
        end
    end

    // Main sequence
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_timing();
        t_off_hit();
        t_full();
        t_part();
        complete_run();
    end
endmodule : fac_core_tb
